// *** core/hisp_defines.svh ***
`ifndef HISP_DEFINES_SVH
`define HISP_DEFINES_SVH

// Strap field positions
`define HISP_STRAP_SERIAL_BIT 2
`define HISP_STRAP_STYLE_BIT 1
`define HISP_STRAP_INT_BIT 0

// Wait state count inserted on each accepted parallel cycle
`define HISP_WAIT_NS 40
`define HISP_CLK_NS 20
`define HISP_WAIT_CYCLES ((`HISP_WAIT_NS + `HISP_CLK_NS - 1) / `HISP_CLK_NS)

// Reset values
`define HISP_STATUS_RESET 8'h00
`define HISP_REG_SEL_RESET 8'h00

`endif

// *** core/hisp_host_port.sv ***
// What this block does
// RQ1 - Straps 00x select separate read/write strobes
// RQ2 - Straps 01x select direction plus enable
// RQ3 - Straps 100/101/11x select serial modes
// RQ4 - Parallel modes use strap bit zero interrupt
// RQ5 - Upper data lines general I/O unless 16-bit
// RQ6 - Serial modes reuse low data lines
// RQ7 - Strobes ignored while chip select high
// RQ8 - Serial mode: chip select is input B0
// RQ9 - Read strobe low makes device drive bus
// RQ10 - Alternate style uses active-high enable strobe
// RQ11 - Serial mode: read pin is input B1
// RQ12 - Command cycle selects register, data cycles transfer
// RQ13 - Device stretches cycles with wait states
// RQ14 - Wait high ready, low holds host
// RQ15 - Select low command/status, high data
// RQ16 - Write pin strobe or direction by style
// RQ17 - Interrupt output reports internal status
`timescale 1ns/1ns
`include "hisp_defines.svh"

module hisp_host_port
   import hisp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Straps and width choice
   input wire logic [2:0] host_mode_strap_i,
   input wire logic bus_16bit_i,
   // Parallel control pins
   input wire logic chip_sel_n_i,
   input wire logic read_enable_i,
   input wire logic write_dir_i,
   input wire logic command_data_select_i,
   // Data bus pins
   input wire logic [15:0] host_data_bus_i,
   output logic [15:0] host_data_bus_o,
   output logic [15:0] host_data_bus_oe_o,
   // Upper bus general I/O
   input wire logic [7:0] upper_bus_general_io_out_i,
   input wire logic [7:0] upper_bus_general_io_oe_i,
   output logic [7:0] upper_bus_general_io_in_o,
   // Serial pins and group B inputs
   output logic [7:0] serial_pins_o,
   output logic [3:0] serial_mode_input_group_b_o,
   // Core side access
   output logic [7:0] reg_sel_o,
   output logic data_wr_o,
   output logic [15:0] data_wdata_o,
   output logic data_rd_o,
   input wire logic [15:0] data_rdata_i,
   input wire logic [7:0] status_i,
   input wire logic core_irq_i,
   // Host status pins
   output logic wait_n_o,
   output logic int_n_o,
   output logic ext_irq_o,
   output logic [4:0] mode_o
);

   // Decodes strap value into mode
   function automatic hisp_mode_type hisp_decode(input logic [2:0] s);
      hisp_mode_type m;
      m = HISP_MODE_P80;
      if (!s[`HISP_STRAP_SERIAL_BIT]) begin
         m = s[`HISP_STRAP_STYLE_BIT] ? HISP_MODE_P68 : HISP_MODE_P80;
      end else if (s[`HISP_STRAP_STYLE_BIT]) begin
         m = HISP_MODE_I2C;
      end else begin
         m = s[`HISP_STRAP_INT_BIT] ? HISP_MODE_SPI4 : HISP_MODE_SPI3;
      end
      return m;
   endfunction : hisp_decode

   //--------------------------------------------------------------
   // Mode and pin function
   //--------------------------------------------------------------
   hisp_mode_type mode_reg, mode_next;
   logic par_mode, wide_bus;
   logic [7:0] gpa_reg, gpa_next, ser_reg, ser_next;
   logic [3:0] gpb_reg, gpb_next;
   logic eirq_reg, eirq_next, int_n_reg, int_n_next;

   // Mode decode and pin reuse
   always_comb begin
      mode_next = hisp_decode(host_mode_strap_i); // RQ1 RQ2 RQ3
      par_mode = (mode_reg == HISP_MODE_P80) || (mode_reg == HISP_MODE_P68);
      wide_bus = par_mode && bus_16bit_i;
      gpa_next = host_data_bus_i[15:8]; // RQ5
      ser_next = par_mode ? 8'h00 : host_data_bus_i[7:0]; // RQ6
      gpb_next = par_mode ? 4'h0 : {command_data_select_i, write_dir_i,
                                    read_enable_i, chip_sel_n_i}; // RQ8 RQ11
      // Interrupt strap follows the strap decode, not the registered mode
      eirq_next = (mode_next == HISP_MODE_P80 || mode_next == HISP_MODE_P68)
                  && host_mode_strap_i[`HISP_STRAP_INT_BIT]; // RQ4
      int_n_next = !(core_irq_i || eirq_reg); // RQ17
   end

   // Mode registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mode_reg <= HISP_MODE_P80;
         gpa_reg <= 8'h00;
         ser_reg <= 8'h00;
         gpb_reg <= 4'h0;
         eirq_reg <= 1'b0;
         int_n_reg <= 1'b1;
      end else begin
         mode_reg <= mode_next;
         gpa_reg <= gpa_next;
         ser_reg <= ser_next;
         gpb_reg <= gpb_next;
         eirq_reg <= eirq_next;
         int_n_reg <= int_n_next;
      end
   end

   //--------------------------------------------------------------
   // Parallel cycle engine
   //--------------------------------------------------------------
   hisp_state_type st_reg, st_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [7:0] sel_reg, sel_next;
   logic [15:0] dout_reg, dout_next, doe_next;
   logic wait_n_reg, wait_n_next, wr_reg, wr_next, rd_reg, rd_next;
   logic [15:0] wdat_reg, wdat_next;
   logic strobe, is_read, is_p68;

   // Strobe and direction decode per style
   always_comb begin
      is_p68 = (mode_reg == HISP_MODE_P68);
      strobe = 1'b0;
      is_read = 1'b0;
      if (par_mode && !chip_sel_n_i) begin // RQ7
         if (is_p68) begin
            strobe = read_enable_i; // RQ10
            is_read = write_dir_i; // RQ16
         end else begin
            strobe = !read_enable_i || !write_dir_i; // RQ9 RQ16
            is_read = !read_enable_i;
         end
      end
   end

   // Next state of the cycle engine
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      sel_next = sel_reg;
      dout_next = dout_reg;
      doe_next = 16'h0000;
      wait_n_next = 1'b1;
      wr_next = 1'b0;
      rd_next = 1'b0;
      wdat_next = wdat_reg;
      case (st_reg)
         HISP_ST_IDLE: begin
            if (strobe) begin
               st_next = HISP_ST_WAIT;
               cnt_next = 3'(`HISP_WAIT_CYCLES);
               wait_n_next = 1'b0; // RQ13 RQ14
               rd_next = is_read && command_data_select_i;
            end
         end
         HISP_ST_WAIT: begin
            wait_n_next = 1'b0; // RQ14
            if (is_read) begin
               doe_next = wide_bus ? 16'hFFFF : 16'h00FF; // RQ9
            end
            if (cnt_reg <= 3'h1) begin
               st_next = HISP_ST_DONE;
               wait_n_next = 1'b1;
            end else begin
               cnt_next = cnt_reg - 3'h1;
            end
         end
         HISP_ST_DONE: begin
            if (is_read) begin
               doe_next = wide_bus ? 16'hFFFF : 16'h00FF;
               dout_next = command_data_select_i ? data_rdata_i
                                                 : {8'h00, status_i}; // RQ15
            end else if (!command_data_select_i) begin
               sel_next = host_data_bus_i[7:0]; // RQ12 RQ15
            end else begin
               wr_next = 1'b1; // RQ12
               wdat_next = wide_bus ? host_data_bus_i
                                    : {8'h00, host_data_bus_i[7:0]};
            end
            st_next = HISP_ST_HOLD;
         end
         HISP_ST_HOLD: begin
            if (is_read) begin
               doe_next = wide_bus ? 16'hFFFF : 16'h00FF;
            end
            if (!strobe) begin
               st_next = HISP_ST_IDLE;
               doe_next = 16'h0000;
            end
         end
         default: begin
            st_next = HISP_ST_IDLE;
         end
      endcase
      if (!par_mode) begin
         st_next = HISP_ST_IDLE;
         doe_next = 16'h0000;
      end
   end

   // Cycle engine registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_reg <= HISP_ST_IDLE;
         cnt_reg <= 3'h0;
         sel_reg <= `HISP_REG_SEL_RESET;
         dout_reg <= 16'h0000;
         wait_n_reg <= 1'b1;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         wdat_reg <= 16'h0000;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         sel_reg <= sel_next;
         dout_reg <= dout_next;
         wait_n_reg <= wait_n_next;
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         wdat_reg <= wdat_next;
      end
   end

   //--------------------------------------------------------------
   // Outputs and general I/O driving
   //--------------------------------------------------------------
   logic [15:0] bus_o_reg, bus_o_next, bus_oe_reg, bus_oe_next;

   // Upper lines go to general I/O when not 16-bit
   always_comb begin
      bus_o_next = dout_next;
      bus_oe_next = doe_next;
      if (!wide_bus) begin
         bus_o_next[15:8] = upper_bus_general_io_out_i; // RQ5
         bus_oe_next[15:8] = upper_bus_general_io_oe_i;
      end
      if (!par_mode) begin
         bus_oe_next[7:0] = 8'h00; // RQ6
      end
   end

   // Bus drive registers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bus_o_reg <= 16'h0000;
         bus_oe_reg <= 16'h0000;
      end else begin
         bus_o_reg <= bus_o_next;
         bus_oe_reg <= bus_oe_next;
      end
   end

   assign host_data_bus_o = bus_o_reg;
   assign host_data_bus_oe_o = bus_oe_reg;
   assign upper_bus_general_io_in_o = gpa_reg;
   assign serial_pins_o = ser_reg;
   assign serial_mode_input_group_b_o = gpb_reg;
   assign reg_sel_o = sel_reg;
   assign data_wr_o = wr_reg;
   assign data_wdata_o = wdat_reg;
   assign data_rd_o = rd_reg;
   assign wait_n_o = wait_n_reg;
   assign int_n_o = int_n_reg;
   assign ext_irq_o = eirq_reg;
   assign mode_o = mode_reg;

   //--------------------------------------------------------------
   // Checks
   //--------------------------------------------------------------
   a_cs_blocks_cycle: assert property (@(posedge clk_i) // RQ7
      disable iff (!rst_n_i)
      (st_reg == HISP_ST_IDLE && chip_sel_n_i) |=> st_reg == HISP_ST_IDLE)
      else $error("cycle started with chip select high");
   a_wait_low_start: assert property (@(posedge clk_i) // RQ13
      disable iff (!rst_n_i)
      (st_reg == HISP_ST_IDLE && strobe && par_mode) |=> !wait_n_o)
      else $error("wait not asserted on accepted strobe");
   a_wait_released: assert property (@(posedge clk_i) // RQ14
      disable iff (!rst_n_i)
      $fell(wait_n_o) |-> ##[1:4] wait_n_o)
      else $error("wait held too long");
   a_serial_no_drive: assert property (@(posedge clk_i) // RQ6
      disable iff (!rst_n_i)
      (!par_mode) |=> host_data_bus_oe_o[7:0] == 8'h00)
      else $error("low bus driven in serial mode");
   a_cmd_sets_sel: assert property (@(posedge clk_i) // RQ12
      disable iff (!rst_n_i)
      (st_reg == HISP_ST_DONE && !is_read && !command_data_select_i
       && par_mode) |=> reg_sel_o == $past(host_data_bus_i[7:0]))
      else $error("command cycle did not select register");
   a_data_write: assert property (@(posedge clk_i) // RQ15
      disable iff (!rst_n_i)
      data_wr_o |-> !$past(command_data_select_i, 1) == 1'b0)
      else $error("data write without data select");
   a_group_b_map: assert property (@(posedge clk_i) // RQ8 RQ11
      disable iff (!rst_n_i)
      (!par_mode) |=> serial_mode_input_group_b_o[1:0] ==
          $past({read_enable_i, chip_sel_n_i}))
      else $error("group B inputs wrong");
   a_ext_irq: assert property (@(posedge clk_i) // RQ4 RQ17
      disable iff (!rst_n_i)
      (!host_mode_strap_i[2] && host_mode_strap_i[0]) |=> ##1 !int_n_o)
      else $error("strap interrupt not reported");
   a_read_drives: assert property (@(posedge clk_i) // RQ9
      disable iff (!rst_n_i)
      host_data_bus_oe_o[0] |-> $past(par_mode))
      else $error("bus driven outside parallel mode");

endmodule : hisp_host_port

// *** core/hisp_pkg.sv ***
package hisp_pkg;

   // Host port mode decoded from the straps
   typedef enum logic [4:0] {
      HISP_MODE_P80 = 5'b00001,
      HISP_MODE_P68 = 5'b00010,
      HISP_MODE_SPI3 = 5'b00100,
      HISP_MODE_SPI4 = 5'b01000,
      HISP_MODE_I2C = 5'b10000
   } hisp_mode_type;

   // Parallel cycle state machine
   typedef enum logic [3:0] {
      HISP_ST_IDLE = 4'b0001,
      HISP_ST_WAIT = 4'b0010,
      HISP_ST_DONE = 4'b0100,
      HISP_ST_HOLD = 4'b1000
   } hisp_state_type;

endpackage : hisp_pkg

// *** sim/hisp_host_model.sv ***
`timescale 1ns/1ns

module hisp_host_model (
   // Clock
   input wire logic clk_i,
   // Device answers
   input wire logic wait_n_i,
   input wire logic [15:0] bus_i,
   // Host pins
   output logic cs_n_o,
   output logic rd_en_o,
   output logic wr_dir_o,
   output logic sel_o,
   output logic data_oe_o,
   output logic [15:0] data_o,
   // Wait cycles seen in the last transfer
   output int wait_cnt_o
);

   // Puts every host pin at once
   task pins(input logic [20:0] v);
      {cs_n_o, rd_en_o, wr_dir_o, sel_o, data_oe_o, data_o} <= v;
   endtask : pins

   // Starts idle with chip select high
   initial begin
      pins({5'h1C, 16'h0000});
      wait_cnt_o = 0;
   end

   // One parallel transfer in either style
   task cycle(input logic p, input logic rd, input logic cs_n,
              input logic sel, input logic [15:0] wd,
              output logic [15:0] rdq);
      int n;
      @(posedge clk_i);
      // Read strobe low in strobe style, enable high in enable style
      pins({cs_n, p | ~rd, rd, sel, ~rd, wd});
      wait_cnt_o = 0;
      n = 0;
      // Strobe stays until ready returns after a wait
      do begin
         @(posedge clk_i);
         if (!wait_n_i) wait_cnt_o++;
         n++;
      end while (n < 12 && !(wait_cnt_o > 0 && wait_n_i));
      @(posedge clk_i);
      rdq = bus_i;
      // Release: data lines let go, strobe back to idle level
      pins({1'b1, ~p, 1'b1, sel, 1'b0, ~wd});
      @(posedge clk_i);
   endtask : cycle

endmodule : hisp_host_model

// *** sim/host_interface_select_parallel_port_bench.sv ***
`timescale 1ns/1ns
`include "hisp_defines.svh"

module host_interface_select_parallel_port_bench;
   import hisp_pkg::*;

   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] strap = 3'h0;
   logic bus16 = 1'b1;
   logic irq = 1'b0;
   logic tog = 1'b0;
   logic [15:0] rdata = 16'h0000;
   logic [7:0] status = 8'h00;
   logic [7:0] gp_out = 8'h00;
   logic [7:0] gp_oe = 8'h00;
   logic h_cs_n, h_rd, h_wr, h_sel, h_oe, wr_p, rd_p;
   logic wait_n, int_n, ext_irq;
   logic [15:0] h_d, bus_w, dbo, doe, wd_o, r, w, m;
   logic [15:0] last_wd = 16'h0000;
   logic [7:0] gp_in, sp, reg_sel;
   logic [3:0] gb;
   logic [4:0] mode;
   int seed = 93;
   int miscompares = 0;
   int n_checks = 0;
   int n_wr = 0;
   int n_rd = 0;
   int hwait, s, p, k;

   // Clock and pin resolution, floating lines toggle
   always #10 clk = ~clk;
   assign bus_w = (doe & dbo) | (~doe & (h_oe ? h_d : {16{tog}}));

   // Float pattern and pulse tally
   always @(posedge clk) begin
      tog <= ~tog;
      if (wr_p) n_wr <= n_wr + 1;
      if (wr_p) last_wd <= wd_o;
      if (rd_p) n_rd <= n_rd + 1;
   end

   hisp_host_model host_u (
      .clk_i(clk),
      .wait_n_i(wait_n),
      .bus_i(bus_w),
      .cs_n_o(h_cs_n),
      .rd_en_o(h_rd),
      .wr_dir_o(h_wr),
      .sel_o(h_sel),
      .data_oe_o(h_oe),
      .data_o(h_d),
      .wait_cnt_o(hwait)
   );

   hisp_host_port dut_u (
      .clk_i(clk),
      .rst_n_i(rst_n),
      .host_mode_strap_i(strap),
      .bus_16bit_i(bus16),
      .chip_sel_n_i(h_cs_n),
      .read_enable_i(h_rd),
      .write_dir_i(h_wr),
      .command_data_select_i(h_sel),
      .host_data_bus_i(bus_w),
      .host_data_bus_o(dbo),
      .host_data_bus_oe_o(doe),
      .upper_bus_general_io_out_i(gp_out),
      .upper_bus_general_io_oe_i(gp_oe),
      .upper_bus_general_io_in_o(gp_in),
      .serial_pins_o(sp),
      .serial_mode_input_group_b_o(gb),
      .reg_sel_o(reg_sel),
      .data_wr_o(wr_p),
      .data_wdata_o(wd_o),
      .data_rd_o(rd_p),
      .data_rdata_i(rdata),
      .status_i(status),
      .core_irq_i(irq),
      .wait_n_o(wait_n),
      .int_n_o(int_n),
      .ext_irq_o(ext_irq),
      .mode_o(mode)
   );

   // Expected one-hot mode for a strap value
   function automatic logic [4:0] exp_mode(input logic [2:0] v);
      if (!v[2]) return v[1] ? 5'h02 : 5'h01;
      if (v[1]) return 5'h10;
      return v[0] ? 5'h08 : 5'h04;
   endfunction : exp_mode

   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         miscompares++;
      end
   endtask : chk

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task hc(input logic rd, input logic cs_n, input logic sel);
      host_u.cycle(p[0], rd, cs_n, sel, w, r);
      #1;
   endtask : hc

   task conclude;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude

   // Main sequence
   initial begin
      tick(3);
      chk("reset", 16'h0061, {9'h000, wait_n, int_n, mode});
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      tick(2);
      for (s = 0; s < 8; s++) begin
         @(posedge clk);
         strap <= s[2:0];
         tick(3);
         chk("mode", {11'h000, exp_mode(s[2:0])}, {11'h000, mode});
         chk("ext_irq", {15'h0000, ~s[2] & s[0]}, {15'h0000, ext_irq});
      end
      $display("test modes done");
      for (k = 0; k < 6; k++) begin
         w = 16'($random(seed));
         @(posedge clk);
         strap <= {1'b1, k[1:0]};
         host_u.pins({w[3:0], 1'b1, w});
         tick(3);
         chk("group_b", {12'h000, w[0], w[1], w[2], w[3]}, {12'h000, gb});
         chk("serial", {8'h00, w[7:0]}, {8'h00, sp});
         chk("upper_io", {8'h00, w[15:8]}, {8'h00, gp_in});
         chk("wait", 16'h0001, {15'h0000, wait_n});
      end
      @(posedge clk);
      host_u.pins({5'h1C, 16'h0000});
      irq <= 1'b1;
      tick(3);
      chk("int_n", 16'h0000, {15'h0000, int_n});
      @(posedge clk);
      irq <= 1'b0;
      tick(3);
      chk("int_n", 16'h0001, {15'h0000, int_n});
      $display("test serial done");
      for (p = 0; p < 2; p++) begin
         @(posedge clk);
         strap <= {1'b0, p[0], 1'b0};
         host_u.pins({1'b1, ~p[0], 3'b100, 16'h0000});
         tick(3);
         for (k = 0; k < 8; k++) begin
            @(posedge clk);
            bus16 <= k[0];
            rdata <= 16'($random(seed));
            status <= 8'($random(seed));
            gp_out <= 8'($random(seed));
            gp_oe <= 8'($random(seed));
            w = 16'($random(seed));
            m = k[0] ? 16'hFFFF : 16'h00FF;
            hc(1'b0, 1'b0, 1'b0);
            chk("reg_sel", {8'h00, w[7:0]}, {8'h00, reg_sel});
            chk("wait_len", 16'(`HISP_WAIT_CYCLES), 16'(hwait));
            hc(1'b0, 1'b0, 1'b1);
            chk("wdata", w & m, last_wd & m);
            hc(1'b1, 1'b0, 1'b1);
            chk("rdata", rdata & m, r & m);
            // Narrow bus: upper lines carry the general I/O drive
            if (!k[0]) begin
               chk("gp_drv", 16'(gp_out & gp_oe), 16'(r[15:8] & gp_oe));
            end
            hc(1'b1, 1'b0, 1'b0);
            chk("status", {8'h00, status}, r & 16'h00FF);
            w = ~w;
            hc(1'b0, 1'b1, 1'b0);
            chk("cs_high", {8'h00, ~w[7:0]}, {8'h00, reg_sel});
            chk("no_wait", 16'h0000, 16'(hwait));
         end
         chk("pulses", 16'(2056 * (p + 1)), {n_wr[7:0], n_rd[7:0]});
         $display("test parallel style %0d done", p);
      end
      conclude();
   end

   // Watchdog against a hung transfer
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      conclude();
   end

endmodule : host_interface_select_parallel_port_bench
